// ---- common/elb_defines.svh ----
// Offsets, field positions, reset values and sizes of the event log buffer
`ifndef ELB_DEFINES_SVH
`define ELB_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ELB_OFS_CTRL      8'h00
`define ELB_OFS_CONFIG    8'h04
`define ELB_OFS_CAPACITY  8'h08
`define ELB_OFS_COUNT     8'h0C
`define ELB_OFS_UNREAD    8'h10
`define ELB_OFS_IRQ_STAT  8'h14
`define ELB_OFS_IRQ_MASK  8'h18
`define ELB_OFS_MASK_SEL  8'h1C
`define ELB_OFS_MASK_DATA 8'h20
`define ELB_OFS_POP_W0    8'h24
`define ELB_OFS_LAST_W0   8'h28
`define ELB_OFS_LAST_W1   8'h2C
`define ELB_OFS_LAST_W2   8'h30
`define ELB_OFS_VIEW_CTRL 8'h34
`define ELB_OFS_VIEW_W0   8'h38
`define ELB_OFS_VIEW_W1   8'h3C
`define ELB_OFS_VIEW_W2   8'h40

// ****************************************
// Field positions
// ****************************************
`define ELB_CTRL_CLEAR    0
`define ELB_CFG_ORDER     0
`define ELB_CFG_SCALING   1
`define ELB_CFG_POPUP     2
`define ELB_IRQ_NEW       0
`define ELB_IRQ_OVF       1
`define ELB_VIEW_FWD      0
`define ELB_VIEW_BACK     1

// ****************************************
// Sizes and reset values
// ****************************************
`define ELB_DEPTH_MAX     2048
`define ELB_CAP_RESET     11'h0C8
`define ELB_CAP_MIN       11'h032
`define ELB_CAP_MAX       11'h7D0
`define ELB_CFG_RESET     3'h0
`define ELB_IRQ_MASK_RST  2'h0
`define ELB_CHANNELS      64

`endif

// ---- common/elb_pkg.sv ----
// Types shared by the event log buffer
package elb_pkg;

    typedef logic [10:0] elb_idx_t;

    typedef struct packed {
        logic [5:0]  event_channel;
        logic [4:0]  event_number;
        logic [15:0] fault_value;
    } elb_event_t;

    // Calendar date plus time of day in milliseconds
    typedef struct packed {
        logic [11:0] year;
        logic [3:0]  month;
        logic [4:0]  day;
        logic [26:0] ms_of_day;
    } elb_stamp_t;

    typedef struct packed {
        logic       overflow_marker;
        elb_event_t evt;
        elb_stamp_t stamp;
    } elb_entry_t;

endpackage

// ---- logic/elb_event_log.sv ----
// Circular event log with APB registers, masking and two readers
// Notes on behaviour
// - Each entry holds event identifier plus date and time-of-day stamp.
// - Identifier is event channel plus event number within that channel.
// - Remote side reads only the head event; each read with unread entries advances pointer.
// - Reread registers return last delivered event without advancing.
// - Local viewer steps forward and backward, apart from remote pointer.
// - Masked events are dropped and never written into the buffer.
// - Capacity resets to two hundred entries.
// - Capacity is configurable from fifty to two thousand entries.
// - Event arriving while full overwrites the oldest entry.
// - Overwrite flags the newest entry with an overflow marker.
// - Timestamps kept at one millisecond; source step may be coarser.
// - Setting selects oldest-first or newest-first local listing.
// - Setting selects per-unit or primary fault value scaling.
// - Setting enables a popup indication on each newly logged event.
//
// The APB register port and the register offsets are this design's own decisions.
`include "elb_defines.svh"
module elb_event_log
    import elb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        evt_valid,
    input  wire elb_event_t  evt_in,
    input  wire elb_stamp_t  stamp_in,
    output logic             irq,
    output logic             popup,
    output logic             fault_value_scaling
);

    // ****************************************
    // State
    // ****************************************
    elb_entry_t  mem [`ELB_DEPTH_MAX];
    logic [31:0] mask_mem [`ELB_CHANNELS];
    elb_idx_t    cap_q, wr_q, count_q, unread_q, view_q;
    logic [2:0]  cfg_q;
    logic [1:0]  irq_stat_q, irq_mask_q;
    logic [5:0]  mask_sel_q;
    elb_entry_t  last_q, pop_buf_q;
    logic        pop_arm_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, irq_q, popup_q, scaling_q;

    // ****************************************
    // Modular pointer arithmetic
    // ****************************************
    function automatic elb_idx_t mod_add(elb_idx_t a, elb_idx_t b,
                                         elb_idx_t c);
        logic [11:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, c}) begin
            s = s - {1'b0, c};
        end
        return s[10:0];
    endfunction

    function automatic elb_idx_t mod_sub(elb_idx_t a, elb_idx_t b,
                                         elb_idx_t c);
        logic [11:0] s;
        if (a >= b) begin
            s = {1'b0, a} - {1'b0, b};
        end else begin
            s = {1'b0, a} + {1'b0, c} - {1'b0, b};
        end
        return s[10:0];
    endfunction

    function automatic logic [31:0] word_of(elb_entry_t e, logic [1:0] w);
        logic [31:0] r;
        case (w)
            2'd0: r = {e.overflow_marker, 4'h0, e.evt};
            2'd1: r = {11'h000, e.stamp.year, e.stamp.month, e.stamp.day};
            2'd2: r = {5'h00, e.stamp.ms_of_day};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ****************************************
    // APB decode
    // ****************************************
    wire acc_setup = psel & ~penable;
    wire acc_done = psel & penable & pready_q;
    wire wr_done = acc_done & pwrite;
    wire rd_done = acc_done & ~pwrite;
    wire a_ctrl = paddr == `ELB_OFS_CTRL;
    wire a_cfg = paddr == `ELB_OFS_CONFIG;
    wire a_cap = paddr == `ELB_OFS_CAPACITY;
    wire a_cnt = paddr == `ELB_OFS_COUNT;
    wire a_unr = paddr == `ELB_OFS_UNREAD;
    wire a_ist = paddr == `ELB_OFS_IRQ_STAT;
    wire a_imk = paddr == `ELB_OFS_IRQ_MASK;
    wire a_msel = paddr == `ELB_OFS_MASK_SEL;
    wire a_mdat = paddr == `ELB_OFS_MASK_DATA;
    wire a_pop = paddr == `ELB_OFS_POP_W0;
    wire a_l0 = paddr == `ELB_OFS_LAST_W0;
    wire a_l1 = paddr == `ELB_OFS_LAST_W1;
    wire a_l2 = paddr == `ELB_OFS_LAST_W2;
    wire a_vc = paddr == `ELB_OFS_VIEW_CTRL;
    wire a_v0 = paddr == `ELB_OFS_VIEW_W0;
    wire a_v1 = paddr == `ELB_OFS_VIEW_W1;
    wire a_v2 = paddr == `ELB_OFS_VIEW_W2;
    wire a_hit = a_ctrl | a_cfg | a_cap | a_cnt | a_unr | a_ist | a_imk |
                 a_msel | a_mdat | a_pop | a_l0 | a_l1 | a_l2 | a_vc |
                 a_v0 | a_v1 | a_v2;

    // ****************************************
    // Logging path
    // ****************************************
    wire masked = mask_mem[evt_in.event_channel][evt_in.event_number];
    wire log_en = evt_valid & ~masked;
    wire full = count_q == cap_q;
    wire at_cap = unread_q == cap_q;
    elb_entry_t new_entry;
    assign new_entry.overflow_marker = full;
    assign new_entry.evt = evt_in;
    assign new_entry.stamp = stamp_in;

    // ****************************************
    // Readers
    // ****************************************
    wire elb_idx_t head_idx = mod_sub(wr_q, unread_q, cap_q);
    wire elb_idx_t oldest_idx = mod_sub(wr_q, count_q, cap_q);
    wire elb_idx_t view_old = mod_add(oldest_idx, view_q, cap_q);
    wire elb_idx_t view_new = mod_sub(wr_q, view_q + 11'd1, cap_q);
    // Order setting only remaps the local position, never the contents
    wire elb_idx_t view_idx = cfg_q[`ELB_CFG_ORDER] ? view_new
                                                     : view_old;
    wire elb_entry_t head_e = mem[head_idx];
    wire elb_entry_t view_e = mem[view_idx];
    wire pop_fire = rd_done & pop_arm_q;
    wire clr_cmd = wr_done & a_ctrl & pwdata[`ELB_CTRL_CLEAR];
    wire cap_wr = wr_done & a_cap;
    wire vfwd = wr_done & a_vc & pwdata[`ELB_VIEW_FWD];
    wire vback = wr_done & a_vc & pwdata[`ELB_VIEW_BACK];

    wire [10:0] cap_req = pwdata[10:0];
    wire elb_idx_t cap_clamped =
        (pwdata[31:11] != 21'h0 || cap_req > `ELB_CAP_MAX) ? `ELB_CAP_MAX :
        (cap_req < `ELB_CAP_MIN) ? `ELB_CAP_MIN : cap_req;

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (a_cfg) rdata = {29'h0, cfg_q};
        if (a_cap) rdata = {21'h0, cap_q};
        if (a_cnt) rdata = {21'h0, count_q};
        if (a_unr) rdata = {21'h0, unread_q};
        if (a_ist) rdata = {30'h0, irq_stat_q};
        if (a_imk) rdata = {30'h0, irq_mask_q};
        if (a_msel) rdata = {26'h0, mask_sel_q};
        if (a_mdat) rdata = mask_mem[mask_sel_q];
        if (a_pop && unread_q != 11'd0) rdata = word_of(head_e, 2'd0);
        if (a_l0) rdata = word_of(last_q, 2'd0);
        if (a_l1) rdata = word_of(last_q, 2'd1);
        if (a_l2) rdata = word_of(last_q, 2'd2);
        if (a_vc) rdata = {21'h0, view_q};
        if (a_v0) rdata = word_of(view_e, 2'd0);
        if (a_v1) rdata = word_of(view_e, 2'd1);
        if (a_v2) rdata = word_of(view_e, 2'd2);
    end

    // ****************************************
    // Next pointer values
    // ****************************************
    wire wrap_clr = clr_cmd | cap_wr;
    wire elb_idx_t wr_d = wrap_clr ? 11'd0 :
        log_en ? mod_add(wr_q, 11'd1, cap_q) : wr_q;
    wire elb_idx_t count_d = wrap_clr ? 11'd0 :
        (log_en & ~full) ? count_q + 11'd1 : count_q;
    // Full and unpolled: oldest unread is lost, unread stays at capacity
    wire elb_idx_t unread_d = wrap_clr ? 11'd0 :
        unread_q + {10'h0, log_en & ~at_cap} -
        {10'h0, pop_fire};
    wire elb_idx_t view_d = (wrap_clr | count_d == 11'd0) ? 11'd0 :
        (vfwd && view_q + 11'd1 < count_q) ? view_q + 11'd1 :
        (vback && view_q != 11'd0) ? view_q - 11'd1 :
        (view_q >= count_d) ? count_d - 11'd1 : view_q;
    wire [1:0] irq_set = {log_en & full, log_en};
    wire [1:0] irq_clr = (wr_done & a_ist) ? pwdata[1:0] : 2'b00;
    // Set wins over a simultaneous write-one-to-clear
    wire [1:0] irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);

    // ****************************************
    // Entry and mask storage
    // ****************************************
    always_ff @(posedge pclk) begin
        if (log_en) begin
            mem[wr_q] <= new_entry;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `ELB_CHANNELS; i++) begin
                mask_mem[i] <= 32'h0000_0000;
            end
        end else if (wr_done & a_mdat) begin
            mask_mem[mask_sel_q] <= pwdata;
        end
    end

    // ****************************************
    // Pointers and configuration
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q <= `ELB_CAP_RESET;
            wr_q <= 11'd0;
            count_q <= 11'd0;
            unread_q <= 11'd0;
            view_q <= 11'd0;
        end else begin
            if (cap_wr) cap_q <= cap_clamped;
            wr_q <= wr_d;
            count_q <= count_d;
            unread_q <= unread_d;
            view_q <= view_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `ELB_CFG_RESET;
            irq_mask_q <= `ELB_IRQ_MASK_RST;
            irq_stat_q <= 2'b00;
            mask_sel_q <= 6'h00;
        end else begin
            if (wr_done & a_cfg) cfg_q <= pwdata[2:0];
            if (wr_done & a_imk) irq_mask_q <= pwdata[1:0];
            if (wr_done & a_msel) mask_sel_q <= pwdata[5:0];
            irq_stat_q <= irq_stat_d;
        end
    end

    // ****************************************
    // Remote delivery
    // ****************************************
    // Head captured at setup so a late overwrite cannot tear the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_arm_q <= 1'b0;
            pop_buf_q <= '0;
            last_q <= '0;
        end else begin
            if (acc_setup) begin
                pop_arm_q <= a_pop & ~pwrite & (unread_q != 11'd0);
                pop_buf_q <= head_e;
            end
            if (pop_fire) last_q <= pop_buf_q;
            if (clr_cmd | cap_wr) last_q <= '0;
        end
    end

    // ****************************************
    // Bus answer and outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc_setup;
            // Error stands only alongside pready, never beyond it
            pslverr_q <= acc_setup & ~a_hit;
            if (acc_setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            popup_q <= 1'b0;
            scaling_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_q);
            popup_q <= log_en & cfg_q[`ELB_CFG_POPUP];
            scaling_q <= cfg_q[`ELB_CFG_SCALING];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign popup = popup_q;
    assign fault_value_scaling = scaling_q;

endmodule

// ---- tb/elb_evt_source.sv ----
// Event source model feeding stamped events into the log
module elb_evt_source
    import elb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [5:0] chan,
    input wire logic [4:0] num,
    output logic evt_valid,
    output elb_event_t evt_in,
    output elb_stamp_t stamp_in
);
    // ****************************************
    // Source
    // ****************************************
    // Coarse 5 ms step, as a protection stage would stamp
    logic [26:0] ms_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_valid <= 1'b0;
            evt_in <= '0;
            stamp_in <= '0;
            ms_q <= 27'h0;
        end else if (go) begin
            evt_valid <= 1'b1;
            ms_q <= ms_q + 27'h5;
            evt_in <= '{chan, num, {5'h00, chan, num}};
            stamp_in <= '{12'h7E9, 4'h1, 5'h1F, ms_q + 27'h5};
        end else begin
            // Stale data would hide a sampling slip
            evt_valid <= 1'b0;
            evt_in <= ~evt_in;
            stamp_in <= ~stamp_in;
        end
    end
endmodule

// ---- tb/elb_monitor.sv ----
// Port checker for the event log buffer
module elb_monitor
    import elb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic evt_valid,
    input wire elb_event_t evt_in,
    input wire elb_stamp_t stamp_in,
    input wire logic irq,
    input wire logic popup,
    input wire logic fault_value_scaling
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    AST_READY_AFTER_SETUP: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response not clean");
    AST_POPUP_CAUSE: assert property (popup |-> $past(evt_valid))
        else $error("popup without event");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(evt_valid)
        || $past(evt_valid, 2) || $past(pwrite && pready)
        || $past(pwrite && pready, 2))
        else $error("irq rose without cause");
    // Only register writes may drop the interrupt
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(pwrite && pready)
        || $past(pwrite && pready, 2))
        else $error("irq fell without write");
    AST_SCALE_CAUSE: assert property ($changed(fault_value_scaling)
        |-> $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("scaling changed without write");
endmodule

bind elb_event_log elb_monitor elb_monitor_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_valid(evt_valid), .evt_in(evt_in),
    .stamp_in(stamp_in), .irq(irq), .popup(popup),
    .fault_value_scaling(fault_value_scaling));

// ---- tb/testbench.sv ----
// Register-level testbench for the event log buffer
`include "elb_defines.svh"
module testbench
    import elb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic evt_valid, irq, popup, fault_value_scaling, go, err, pu;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] chan;
    logic [4:0] num;
    elb_event_t evt_in;
    elb_stamp_t stamp_in;
    int n_errors, total_checks, cyc, n_sent;
    elb_event_log elb_event_log_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_valid(evt_valid), .evt_in(evt_in),
        .stamp_in(stamp_in), .irq(irq), .popup(popup),
        .fault_value_scaling(fault_value_scaling));
    elb_evt_source elb_evt_source_i (.pclk(pclk), .presetn(presetn),
        .go(go), .chan(chan), .num(num), .evt_valid(evt_valid),
        .evt_in(evt_in), .stamp_in(stamp_in));
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Ends on pready; with no limit of its own, only the bench timeout ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task ev(input logic [5:0] c, input logic [4:0] n);
        @(posedge pclk);
        {go, chan, num} <= {1'b1, c, n};
        @(posedge pclk);
        go <= 1'b0;
        n_sent++;
        repeat (2) @(posedge pclk);
        pu = popup;
    endtask
    function automatic logic [31:0] w0(logic o, logic [5:0] c,
        logic [4:0] n);
        return {o, 4'h0, c, n, 5'h00, c, n};
    endfunction
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Clock, timeout and sequence
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {go, chan, num, n_errors, total_checks, cyc, n_sent} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("cap", `ELB_OFS_CAPACITY, 32'h0C8);
        rdc("count", `ELB_OFS_COUNT, 32'h0);
        rdc("config", `ELB_OFS_CONFIG, 32'h0);
        rdc("irqmask", `ELB_OFS_IRQ_MASK, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped rd", rd, 32'h0);
        wr(`ELB_OFS_CAPACITY, 32'h5);
        rdc("cap lo", `ELB_OFS_CAPACITY, 32'h32);
        wr(`ELB_OFS_CAPACITY, 32'hFFF);
        rdc("cap hi", `ELB_OFS_CAPACITY, 32'h7D0);
        wr(`ELB_OFS_MASK_SEL, 32'h3);
        wr(`ELB_OFS_MASK_DATA, 32'h2);
        ev(6'h03, 5'h01);
        rdc("masked", `ELB_OFS_COUNT, 32'h0);
        ev(6'h03, 5'h02);
        chk("popup off", pu, 1'b0);
        rdc("kept", `ELB_OFS_COUNT, 32'h1);
        chk("irq masked", irq, 1'b0);
        wr(`ELB_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq on", irq, 1'b1);
        wr(`ELB_OFS_IRQ_STAT, 32'h1);
        rdc("stat clr", `ELB_OFS_IRQ_STAT, 32'h0);
        chk("irq off", irq, 1'b0);
        rdc("pop", `ELB_OFS_POP_W0,
            w0(1'b0, 6'h03, 5'h02));
        repeat (2) rdc("last0", `ELB_OFS_LAST_W0,
            w0(1'b0, 6'h03, 5'h02));
        rdc("last1", `ELB_OFS_LAST_W1, 32'h000FD23F);
        rdc("last2", `ELB_OFS_LAST_W2, 32'(5 * n_sent));
        rdc("unread", `ELB_OFS_UNREAD, 32'h0);
        rdc("pop empty", `ELB_OFS_POP_W0, 32'h0);
        wr(`ELB_OFS_CAPACITY, 32'h32);
        wr(`ELB_OFS_CONFIG, 32'h4);
        ev(6'h01, 5'h01);
        chk("popup on", pu, 1'b1);
        // Back-to-back burst: two entries past a 50-deep log
        for (int i = 0; i < 51; i++) begin
            @(posedge pclk);
            {go, chan, num} <= {1'b1, 6'(i + 4), 5'(i)};
        end
        @(posedge pclk);
        go <= 1'b0;
        n_sent += 51;
        repeat (3) @(posedge pclk);
        rdc("full", `ELB_OFS_COUNT, 32'h32);
        rdc("ovf stat", `ELB_OFS_IRQ_STAT, 32'h3);
        rdc("oldest", `ELB_OFS_POP_W0, w0(1'b0, 6'h05, 5'h01));
        rdc("view old", `ELB_OFS_VIEW_W0, w0(1'b0, 6'h05, 5'h01));
        wr(`ELB_OFS_CONFIG, 32'h5);
        rdc("view new", `ELB_OFS_VIEW_W0,
            w0(1'b1, 6'h36, 5'h12));
        wr(`ELB_OFS_VIEW_CTRL, 32'h1);
        rdc("view fwd", `ELB_OFS_VIEW_W0, w0(1'b1, 6'h35, 5'h11));
        wr(`ELB_OFS_VIEW_CTRL, 32'h2);
        rdc("view back", `ELB_OFS_VIEW_W0, w0(1'b1, 6'h36, 5'h12));
        rdc("unread", `ELB_OFS_UNREAD, 32'h31);
        chk("scale pu", fault_value_scaling, 1'b0);
        wr(`ELB_OFS_CONFIG, 32'h2);
        repeat (2) @(posedge pclk);
        chk("scale pri", fault_value_scaling, 1'b1);
        wr(`ELB_OFS_CTRL, 32'h1);
        rdc("clr count", `ELB_OFS_COUNT, 32'h0);
        rdc("clr unread", `ELB_OFS_UNREAD, 32'h0);
        rdc("clr last", `ELB_OFS_LAST_W0, 32'h0);
        wr(`ELB_OFS_IRQ_STAT, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq end", irq, 1'b0);
        wrap_up;
    end
endmodule
